// ==== adc_mode_pkg.sv ====
// Package with register map, field layout, mode codes and settling delay constants.
package adc_mode_pkg;

   // Register addresses on the internal register port.
   localparam logic [5:0]  MODE_CTRL_ADDR  = 6'h01;
   localparam logic [5:0]  IF_OPTS_ADDR    = 6'h02;

   // Reset values.
   localparam logic [15:0] MODE_CTRL_RESET = 16'h2000;
   localparam logic [15:0] IF_OPTS_RESET   = 16'h0000;

   // Writable bit masks; the other positions read as zero.
   localparam logic [15:0] MODE_CTRL_WMASK = 16'he77c;
   localparam logic [15:0] IF_OPTS_WMASK   = 16'h19ff;

   // Field positions of the mode control register and of the interface options register.
   localparam int REF_EN_BIT       = 15;
   localparam int SETTLED_BIT      = 13;
   localparam int DELAY_LSB        = 8;
   localparam int MODE_LSB         = 4;
   localparam int CLKSEL_LSB       = 2;
   localparam int CONTINUOUS_READOUT_ENABLE_BIT     = 7;

   // Operating mode codes.
   localparam logic [2:0] MODE_CONTINUOUS = 3'h0;
   localparam logic [2:0] MODE_SINGLE     = 3'h1;
   localparam logic [2:0] MODE_STANDBY    = 3'h2;
   localparam logic [2:0] MODE_POWERDOWN  = 3'h3;
   localparam logic [2:0] MODE_INT_OFFSET = 3'h4;
   localparam logic [2:0] MODE_INT_GAIN   = 3'h5;
   localparam logic [2:0] MODE_SYS_OFFSET = 3'h6;
   localparam logic [2:0] MODE_SYS_GAIN   = 3'h7;

   // Clock source codes.
   localparam logic [1:0] CLK_INT_OSC     = 2'h0;
   localparam logic [1:0] CLK_INT_OSC_OUT = 2'h1;
   localparam logic [1:0] CLK_EXT_CLOCK   = 2'h2;
   localparam logic [1:0] CLK_CRYSTAL     = 2'h3;

   // System clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 10;

   // Settling delay times in microseconds, as printed.
   localparam int DELAY1_US = 32;
   localparam int DELAY2_US = 128;
   localparam int DELAY3_US = 320;
   localparam int DELAY4_US = 800;
   localparam int DELAY5_US = 1600;
   localparam int DELAY6_US = 4000;
   localparam int DELAY7_US = 8000;

   // Settling delay times in clock cycles.
   localparam int DELAY1_CYC = DELAY1_US * 1000 / CLK_PERIOD_NS;
   localparam int DELAY2_CYC = DELAY2_US * 1000 / CLK_PERIOD_NS;
   localparam int DELAY3_CYC = DELAY3_US * 1000 / CLK_PERIOD_NS;
   localparam int DELAY4_CYC = DELAY4_US * 1000 / CLK_PERIOD_NS;
   localparam int DELAY5_CYC = DELAY5_US * 1000 / CLK_PERIOD_NS;
   localparam int DELAY6_CYC = DELAY6_US * 1000 / CLK_PERIOD_NS;
   localparam int DELAY7_CYC = DELAY7_US * 1000 / CLK_PERIOD_NS;

   // Width of the settling counter.
   localparam int DELAY_CNT_W = 20;

   // Sequencer states, Gray coded along idle, settle, run.
   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b00,
      SEQ_SETTLE = 2'b01,
      SEQ_RUN    = 2'b11
   } seq_state_t;

endpackage

// ==== adc_mode_control_register.sv ====
// Mode control and interface options registers with the conversion start sequencer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] Mode register at address 1, resets 0x2000.
// [RULE2] Mode write clears filter, ready; restarts.
// [RULE3] Bit 15 enables reference and its output.
// [RULE4] Bit 13 limits output to settled rate.
// [RULE5] Bits 10:8 set channel switch settling wait.
// [RULE6] Bits 6:4 select the operating mode.
// [RULE7] Bits 3:2 select the master clock source.
// [RULE8] Internal oscillator selection powers the oscillator.
// [RULE9] Host writes zero to reserved bits.
// [RULE10] Interface options at address 2, resets zero.
// [RULE11] Continuous readout only in continuous mode.
module adc_mode_control_register
   import adc_mode_pkg::*;
#(
   parameter int DELAY2_CYCLES = DELAY2_CYC,   // 128 us settling wait.
   parameter int DELAY3_CYCLES = DELAY3_CYC,   // 320 us settling wait.
   parameter int DELAY4_CYCLES = DELAY4_CYC,   // 800 us settling wait.
   parameter int DELAY5_CYCLES = DELAY5_CYC,   // 1.6 ms settling wait.
   parameter int DELAY6_CYCLES = DELAY6_CYC,   // 4 ms settling wait.
   parameter int DELAY7_CYCLES = DELAY7_CYC    // 8 ms settling wait.
)(
   input  wire logic        sys_clk,           // System clock, 100 MHz.
   input  wire logic        reset_n,           // Synchronous reset, active low.
   input  wire logic [5:0]  regAddr,           // Register address from the serial core.
   input  wire logic [15:0] regWrData,         // Write data from the serial core.
   input  wire logic        regWrEn,           // One-cycle write strobe.
   input  wire logic        regRdEn,           // One-cycle read strobe.
   output logic      [15:0] regRdData,         // Read data, registered.
   output logic             regRdValid,        // Read data valid pulse.
   input  wire logic        channelSwitch,     // Pulse: the sequencer moved to a new channel.
   input  wire logic        resultDone,        // Pulse: the filter produced a result.
   output logic             filterClear,       // Pulse: clear the digital filter state.
   output logic             conversionStart,   // Pulse: start conversion or calibration.
   output logic             inputProcessEnable,// High once the settling wait has passed.
   output logic             conversionReady,   // Ready flag, active high.
   output logic             referenceEnable,   // Internal reference and its buffer on.
   output logic             settledOnlyOutput, // Output only at the settled filter rate.
   output logic      [2:0]  operatingMode,     // Selected operating mode.
   output logic      [1:0]  clockSourceSelect, // Selected master clock source.
   output logic             oscillatorEnable,  // Internal oscillator powered.
   output logic             clockIoDriveOut_n, // Low while the clock I/O pin is driven out.
   output logic             crystalEnable,     // Crystal oscillator across both pins.
   output logic             continuousReadoutEnable // Continuous result readout enabled.
);

   // Register state.
   logic [15:0]             modeCtrl_reg;      // Mode control register.
   logic [15:0]             modeCtrl_next;
   logic [15:0]             ifOpts_reg;        // Interface options register.
   logic [15:0]             ifOpts_next;
   logic [15:0]             rdData_reg;        // Read data holding register.
   logic [15:0]             rdData_next;
   logic                    rdValid_reg;       // Read valid pulse.
   logic                    rdValid_next;

   // Sequencer state.
   seq_state_t              state_reg;
   seq_state_t              state_next;
   logic [DELAY_CNT_W-1:0]  count_reg;         // Settling cycles left.
   logic [DELAY_CNT_W-1:0]  count_next;
   logic                    ready_reg;         // Conversion ready flag.
   logic                    ready_next;
   logic                    clear_reg;         // Filter clear pulse.
   logic                    clear_next;
   logic                    start_reg;         // Start pulse.
   logic                    start_next;

   // Decoded write strobes.
   logic                    modeWrite;
   logic                    ifWrite;
   logic [DELAY_CNT_W-1:0]  delayLoad;         // Wait chosen by the delay field.
   logic                    modeActive;        // Mode converts or calibrates.

   // Turns the delay code into a cycle count.
   function automatic logic [DELAY_CNT_W-1:0] delay_cycles(input logic [2:0] code);
      int cyc;
      case (code)
         3'h0: cyc = 0;
         3'h1: cyc = DELAY1_CYC;
         3'h2: cyc = DELAY2_CYCLES;
         3'h3: cyc = DELAY3_CYCLES;
         3'h4: cyc = DELAY4_CYCLES;
         3'h5: cyc = DELAY5_CYCLES;
         3'h6: cyc = DELAY6_CYCLES;
         default: cyc = DELAY7_CYCLES;
      endcase
      return cyc[DELAY_CNT_W-1:0];
   endfunction

   // Address decode of the register port.
   always_comb begin
      modeWrite = regWrEn && (regAddr == MODE_CTRL_ADDR); // [RULE1]
      ifWrite   = regWrEn && (regAddr == IF_OPTS_ADDR);   // [RULE10]
   end

   // Next values of the register bank.
   always_comb begin
      modeCtrl_next = modeCtrl_reg;
      ifOpts_next   = ifOpts_reg;
      rdData_next   = rdData_reg;
      rdValid_next  = 1'b0;
      // Reserved read-only positions are masked so they stay zero.
      if (modeWrite) begin
         modeCtrl_next = regWrData & MODE_CTRL_WMASK; // [RULE9]
      end
      if (ifWrite) begin
         ifOpts_next = regWrData & IF_OPTS_WMASK;
      end
      // Reads return the register or zero for unmapped addresses.
      if (regRdEn) begin
         rdValid_next = 1'b1;
         if (regAddr == MODE_CTRL_ADDR) begin
            rdData_next = modeCtrl_reg;
         end else if (regAddr == IF_OPTS_ADDR) begin
            rdData_next = ifOpts_reg;
         end else begin
            rdData_next = 16'h0000;
         end
      end
   end

   // Register bank flip-flops.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         modeCtrl_reg <= MODE_CTRL_RESET; // [RULE1]
         ifOpts_reg   <= IF_OPTS_RESET;   // [RULE10]
         rdData_reg   <= 16'h0000;
         rdValid_reg  <= 1'b0;
      end else begin
         modeCtrl_reg <= modeCtrl_next;
         ifOpts_reg   <= ifOpts_next;
         rdData_reg   <= rdData_next;
         rdValid_reg  <= rdValid_next;
      end
   end

   // Field decode that drives the analog and clock controls.
   always_comb begin
      referenceEnable   = modeCtrl_reg[REF_EN_BIT];                    // [RULE3]
      settledOnlyOutput = modeCtrl_reg[SETTLED_BIT];                   // [RULE4]
      operatingMode     = modeCtrl_reg[MODE_LSB +: 3];                 // [RULE6]
      clockSourceSelect = modeCtrl_reg[CLKSEL_LSB +: 2];               // [RULE7]
      // The oscillator runs for both internal selections.
      oscillatorEnable  = (clockSourceSelect == CLK_INT_OSC) ||
                          (clockSourceSelect == CLK_INT_OSC_OUT);      // [RULE8]
      clockIoDriveOut_n = !(clockSourceSelect == CLK_INT_OSC_OUT);     // [RULE7]
      crystalEnable     = (clockSourceSelect == CLK_CRYSTAL);          // [RULE7]
      // Readout is only offered while converting continuously.
      continuousReadoutEnable = ifOpts_reg[CONTINUOUS_READOUT_ENABLE_BIT] &&
                                (operatingMode == MODE_CONTINUOUS);    // [RULE11]
      delayLoad  = delay_cycles(modeCtrl_reg[DELAY_LSB +: 3]);         // [RULE5]
      modeActive = (operatingMode != MODE_STANDBY) &&
                   (operatingMode != MODE_POWERDOWN);                  // [RULE6]
   end

   // Sequencer next state: a mode write restarts, a channel switch waits.
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      clear_next = 1'b0;
      start_next = 1'b0;
      ready_next = ready_reg;
      // A write clears the ready flag and beats a result in the same cycle, which is stale.
      if (modeWrite) begin
         ready_next = 1'b0; // [RULE2]
      end
      if (resultDone && state_reg == SEQ_RUN && !modeWrite) begin
         ready_next = 1'b1;
      end
      case (state_reg)
         // Standby and power-down stay idle until a new write.
         SEQ_IDLE: begin
            count_next = '0;
         end
         // Waits out the settling delay, then starts processing.
         SEQ_SETTLE: begin
            if (count_reg == '0) begin
               state_next = SEQ_RUN;
               start_next = 1'b1; // [RULE2]
            end else begin
               count_next = count_reg - 1'b1; // [RULE5]
            end
         end
         // Processing; a channel switch inserts the wait again.
         SEQ_RUN: begin
            if (channelSwitch) begin
               state_next = SEQ_SETTLE;
               count_next = delayLoad; // [RULE5]
            end
         end
         default: begin
            state_next = SEQ_IDLE;
         end
      endcase
      // A write picks idle or settle from the mode field of the write data in the same cycle.
      if (modeWrite) begin
         clear_next = 1'b1; // [RULE2]
         state_next = (regWrData[MODE_LSB +: 3] == MODE_STANDBY ||
                       regWrData[MODE_LSB +: 3] == MODE_POWERDOWN) ?
                      SEQ_IDLE : SEQ_SETTLE;
         count_next = '0;
      end else if (!modeActive && state_reg != SEQ_IDLE) begin
         state_next = SEQ_IDLE;
      end
   end

   // Sequencer flip-flops.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_reg <= SEQ_IDLE;
         count_reg <= '0;
         ready_reg <= 1'b0;
         clear_reg <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         ready_reg <= ready_next;
         clear_reg <= clear_next;
         start_reg <= start_next;
      end
   end

   // Output drive from the state registers.
   always_comb begin
      regRdData          = rdData_reg;
      regRdValid         = rdValid_reg;
      filterClear        = clear_reg;
      conversionStart    = start_reg;
      conversionReady    = ready_reg;
      inputProcessEnable = (state_reg == SEQ_RUN);
   end

endmodule
`default_nettype wire

// ==== adc_mode_chk.sv ====
// Checker of the mode control register block ports.
`timescale 1ns/1ps
`default_nettype none
module adc_mode_chk
   import adc_mode_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic        regWrEn,
   input wire logic        regRdEn,
   input wire logic        regRdValid,
   input wire logic        channelSwitch,
   input wire logic        filterClear,
   input wire logic        conversionStart,
   input wire logic        inputProcessEnable,
   input wire logic        conversionReady,
   input wire logic        referenceEnable,
   input wire logic        settledOnlyOutput,
   input wire logic        oscillatorEnable,
   input wire logic        clockIoDriveOut_n,
   input wire logic        crystalEnable,
   input wire logic        continuousReadoutEnable,
   input wire logic [5:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic [2:0]  operatingMode,
   input wire logic [1:0]  clockSourceSelect
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // A host write aimed at the mode control register.
   wire logic modeWr = regWrEn && regAddr == MODE_CTRL_ADDR;
   property p_clr; modeWr |=> filterClear && !conversionReady; endproperty
   a_clr: assert property (p_clr) else $error("mode write did not clear");
   property p_stay; conversionReady && !modeWr |=> conversionReady; endproperty
   a_stay: assert property (p_stay) else $error("ready flag dropped");
   property p_go; modeWr && regWrData[10:8] == 3'h0 && regWrData[6:5] != 2'b01
      |-> ##2 conversionStart; endproperty
   a_go: assert property (p_go) else $error("no start after mode write");
   property p_ref; modeWr |=> referenceEnable == $past(regWrData[REF_EN_BIT]); endproperty
   a_ref: assert property (p_ref) else $error("reference enable wrong");
   property p_set; modeWr |=> settledOnlyOutput == $past(regWrData[SETTLED_BIT]); endproperty
   a_set: assert property (p_set) else $error("settled output wrong");
   property p_sw; channelSwitch && inputProcessEnable && !regWrEn |=> !inputProcessEnable;
   endproperty
   a_sw: assert property (p_sw) else $error("no wait after switch");
   property p_mode; modeWr |=> operatingMode == $past(regWrData[6:4]); endproperty
   a_mode: assert property (p_mode) else $error("mode field wrong");
   property p_stby; modeWr && regWrData[6:5] == 2'b01 |=> !conversionStart [*4]; endproperty
   a_stby: assert property (p_stby) else $error("start in standby");
   property p_clk; modeWr |=> clockSourceSelect == $past(regWrData[3:2]); endproperty
   a_clk: assert property (p_clk) else $error("clock select wrong");
   property p_osc; oscillatorEnable == !clockSourceSelect[1]
      && crystalEnable == (clockSourceSelect == CLK_CRYSTAL)
      && clockIoDriveOut_n == (clockSourceSelect != CLK_INT_OSC_OUT); endproperty
   a_osc: assert property (p_osc) else $error("clock controls wrong");
   property p_cr; continuousReadoutEnable |-> operatingMode == MODE_CONTINUOUS; endproperty
   a_cr: assert property (p_cr) else $error("readout outside continuous");
   property p_rv; regRdEn |=> regRdValid; endproperty
   a_rv: assert property (p_rv) else $error("no read valid");
endmodule
bind adc_mode_control_register adc_mode_chk adc_mode_chk_inst (.*);
`default_nettype wire

// ==== host_model.sv ====
// Host model issuing register accesses and sequencer pulses.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic        sys_clk,
   output var  logic [5:0]  regAddr,
   output var  logic [15:0] regWrData,
   output var  logic        regWrEn,
   output var  logic        regRdEn,
   output var  logic        channelSwitch,
   output var  logic        resultDone
);
   // Idle values at time zero.
   initial begin
      regAddr = 6'h00;
      regWrData = 16'h0000;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      channelSwitch = 1'b0;
      resultDone = 1'b0;
   end
   // One access; released lines show the inverse so stale values are not trusted.
   task access(input logic wr, input logic [5:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= wr;
      regRdEn <= !wr;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
      regRdEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask
   // One-cycle channel switch or result pulse.
   task pulse(input logic sw);
      @(posedge sys_clk);
      channelSwitch <= sw;
      resultDone <= !sw;
      @(posedge sys_clk);
      channelSwitch <= 1'b0;
      resultDone <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the mode control register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin nMismatch++; \
   $display("Error %s expected %h seen %h", nm, e, a); end end
module testbench
   import adc_mode_pkg::*;
;
   logic        sys_clk, reset_n, regWrEn, regRdEn, channelSwitch, resultDone, regRdValid;
   logic        filterClear, conversionStart, inputProcessEnable, conversionReady;
   logic        referenceEnable, settledOnlyOutput, oscillatorEnable, clockIoDriveOut_n;
   logic        crystalEnable, continuousReadoutEnable;
   logic [5:0]  regAddr;
   logic [15:0] regWrData, regRdData, d, expHead;
   logic [2:0]  operatingMode;
   logic [1:0]  clockSourceSelect;
   logic [15:0] expQ[$];
   int          nMismatch, comparisons, n;
   // Only the four longest waits are shortened; the shorter codes run at full length.
   localparam int SHORT_WAIT4 = 8;
   localparam int SHORT_WAIT5 = 9;
   localparam int SHORT_WAIT6 = 10;
   localparam int SHORT_WAIT7 = 11;
   int          delayTab[8] = '{0, DELAY1_CYC, DELAY2_CYC, DELAY3_CYC,
                                SHORT_WAIT4, SHORT_WAIT5, SHORT_WAIT6, SHORT_WAIT7};
   adc_mode_control_register #(.DELAY4_CYCLES(SHORT_WAIT4), .DELAY5_CYCLES(SHORT_WAIT5),
      .DELAY6_CYCLES(SHORT_WAIT6), .DELAY7_CYCLES(SHORT_WAIT7))
      adc_mode_control_register_inst (.*);
   host_model host_model_inst (.*);
   // Clock at 100 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Prints the counts and the verdict, then ends the run.
   task test_done;
      $display("Comparisons %0d mismatches %0d", comparisons, nMismatch);
      if (nMismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Notes the expected word, then reads.
   task rd(input logic [5:0] a, input logic [15:0] e);
      expQ.push_back(e);
      host_model_inst.access(1'b0, a, 16'h0000);
   endtask
   // Compares each returned word with the oldest note, mid-cycle while the pulse stands.
   always @(negedge sys_clk) begin
      if (regRdValid === 1'b1) begin
         expHead = (expQ.size() > 0) ? expQ.pop_front() : 16'hxxxx;
         `CHK("readData", expHead, regRdData)
      end
   end
   // Cuts a hang short.
   initial begin
      repeat (70000) @(posedge sys_clk);
      nMismatch++;
      test_done;
   end
   // Main sequence.
   initial begin
      reset_n = 1'b0;
      nMismatch = 0;
      comparisons = 0;
      void'($urandom(32'hf814));
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(negedge sys_clk);
      `CHK("settled", 1'b1, settledOnlyOutput)
      `CHK("reference", 1'b0, referenceEnable)
      rd(MODE_CTRL_ADDR, MODE_CTRL_RESET);
      rd(IF_OPTS_ADDR, IF_OPTS_RESET);
      host_model_inst.access(1'b1, 6'h3f, 16'hffff);
      rd(6'h3f, 16'h0000);
      // Readout may be switched on here, since reset leaves continuous conversion selected.
      host_model_inst.access(1'b1, IF_OPTS_ADDR, 16'hffff);
      rd(IF_OPTS_ADDR, IF_OPTS_WMASK);
      host_model_inst.access(1'b1, IF_OPTS_ADDR, 16'h0000);
      // Every writable mode bit but reserved bit 14, which the host keeps zero.
      host_model_inst.access(1'b1, MODE_CTRL_ADDR, MODE_CTRL_WMASK & 16'hbfff);
      rd(MODE_CTRL_ADDR, MODE_CTRL_WMASK & 16'hbfff);
      for (int i = 0; i < 8; i++) begin
         // Each mode once, each clock source twice, reserved bits kept zero by the host.
         d = (16'($urandom()) & 16'ha700) | 16'(i << 4) | 16'((i & 3) << 2);
         // Readout goes off before the mode may leave continuous conversion.
         host_model_inst.access(1'b1, IF_OPTS_ADDR, 16'h0000);
         host_model_inst.access(1'b1, MODE_CTRL_ADDR, d);
         @(negedge sys_clk);
         `CHK("clear", 1'b1, filterClear)
         `CHK("ready", 1'b0, conversionReady)
         `CHK("reference", d[15], referenceEnable)
         `CHK("settled", d[13], settledOnlyOutput)
         `CHK("mode", d[6:4], operatingMode)
         `CHK("clock_source_select", d[3:2], clockSourceSelect)
         `CHK("clockIo", d[3:2] != CLK_INT_OSC_OUT, clockIoDriveOut_n)
         `CHK("crystal", d[3:2] == CLK_CRYSTAL, crystalEnable)
         `CHK("oscillator", ~d[3], oscillatorEnable)
         rd(MODE_CTRL_ADDR, d);
         // Readout is switched on again only while converting continuously.
         host_model_inst.access(1'b1, IF_OPTS_ADDR, 16'(d[6:4] == 3'h0) << 7);
         @(negedge sys_clk);
         `CHK("continuous_readout_enable", d[6:4] == 3'h0, continuousReadoutEnable)
         // Continuous mode with settling code i, then one channel switch.
         host_model_inst.access(1'b1, MODE_CTRL_ADDR, 16'(i << 8));
         n = 0;
         while (inputProcessEnable !== 1'b1 && n < 4000) begin
            @(negedge sys_clk);
            n++;
         end
         host_model_inst.pulse(1'b1);
         n = 0;
         do begin
            @(negedge sys_clk);
            n++;
         end while (conversionStart !== 1'b1 && n < 40000);
         `CHK("settleCycles", delayTab[i] + 2, n)
         host_model_inst.pulse(1'b0);
         @(negedge sys_clk);
         `CHK("ready", 1'b1, conversionReady)
      end
      // A second reset in mid-run must bring back the reset values.
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(negedge sys_clk);
      `CHK("ready", 1'b0, conversionReady)
      `CHK("processEnable", 1'b0, inputProcessEnable)
      `CHK("settled", 1'b1, settledOnlyOutput)
      rd(MODE_CTRL_ADDR, MODE_CTRL_RESET);
      rd(IF_OPTS_ADDR, IF_OPTS_RESET);
      repeat (3) @(posedge sys_clk);
      test_done;
   end
endmodule
`default_nettype wire
